/* core/bal_core.sv */
`timescale 1ns/1ps
module bal_core (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // instruction request
  input wire logic op_valid,
  input wire bal_pkg::bal_op_t op_code,
  input wire logic [2:0] destination_field,
  input wire logic [2:0] source_field,
  input wire logic [1:0] selected_pair,
  input wire logic [7:0] imm_byte,
  output logic op_ready,
  output logic op_done_reg,
  // architectural state
  output logic [7:0] acc_reg,
  output logic [7:0] flags_reg,
  output logic [15:0] pointer_pair,
  output logic [15:0] bc_out,
  output logic [15:0] de_out,
  output logic [15:0] sp_out,
  // memory bus
  output logic mem_rd,
  output logic mem_wr,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ready
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    BAL_ST_IDLE  = 3'b000,
    BAL_ST_READ  = 3'b001,
    BAL_ST_WRITE = 3'b010,
    BAL_ST_WAIT  = 3'b011,
    BAL_ST_DONE  = 3'b100
  } bal_st_t;

  bal_st_t st_reg;
  bal_pkg::bal_op_t op_reg;
  logic [7:0] regs_reg [0:7];
  logic [15:0] sp_reg;
  logic [2:0] dst_reg;
  logic [2:0] src_reg;
  logic [1:0] rp_reg;
  logic [7:0] imm_reg;
  logic [3:0] cnt_reg;
  logic mem_start;
  logic mem_wr_req;
  logic mem_done;
  logic [7:0] mem_byte;
  logic [7:0] alu_res;
  logic [7:0] new_flags;
  logic wr_acc;
  logic wr_dst;
  logic wr_flags;
  logic z_f;
  logic s_f;
  logic p_f;
  logic [15:0] pair_val;
  logic [16:0] dad_sum;
  logic [15:0] pair_res;
  logic is_mem_op;
  logic is_rmw_op;
  logic is_pair_op;

  assign pointer_pair = {regs_reg[bal_pkg::BAL_R_H], regs_reg[bal_pkg::BAL_R_L]};
  assign bc_out = {regs_reg[bal_pkg::BAL_R_B], regs_reg[bal_pkg::BAL_R_C]};
  assign de_out = {regs_reg[bal_pkg::BAL_R_D], regs_reg[bal_pkg::BAL_R_E]};
  assign sp_out = sp_reg;
  assign acc_reg = regs_reg[bal_pkg::BAL_R_A];
  assign op_ready = (st_reg == BAL_ST_IDLE);

  always_comb begin
    is_mem_op = (op_reg == bal_pkg::BAL_OP_SBB_MEM) || (op_reg == bal_pkg::BAL_OP_AND_MEM) ||
                (op_reg == bal_pkg::BAL_OP_XOR_MEM) || (op_reg == bal_pkg::BAL_OP_INC_MEM) ||
                (op_reg == bal_pkg::BAL_OP_DEC_MEM);
    is_rmw_op = (op_reg == bal_pkg::BAL_OP_INC_MEM) || (op_reg == bal_pkg::BAL_OP_DEC_MEM);
    is_pair_op = (op_reg == bal_pkg::BAL_OP_PAIR_INC) || (op_reg == bal_pkg::BAL_OP_PAIR_DEC) ||
                 (op_reg == bal_pkg::BAL_OP_PAIR_ADD);
  end

  // ------------------------------------------------------------
  // memory port; operands at the pointer pair
  // ------------------------------------------------------------
  assign mem_start = (st_reg == BAL_ST_READ) || (st_reg == BAL_ST_WRITE);
  assign mem_wr_req = (st_reg == BAL_ST_WRITE);

  bal_mem_port u_mem (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .start(mem_start),
    .wr(mem_wr_req),
    .addr(pointer_pair),
    .wdata(alu_res),
    .done(mem_done),
    .rdata_reg(mem_byte),
    .mem_rd_reg(mem_rd),
    .mem_wr_reg(mem_wr),
    .mem_addr_reg(mem_addr),
    .mem_wdata_reg(mem_wdata),
    .mem_rdata(mem_rdata),
    .mem_ready(mem_ready)
  );

  // ------------------------------------------------------------
  // byte datapath
  // ------------------------------------------------------------
  bal_flag_calc u_flags (
    .res(alu_res),
    .zero(z_f),
    .sign(s_f),
    .parity(p_f)
  );

  always_comb begin
    logic [7:0] a;
    logic [7:0] opnd;
    logic [8:0] diff;
    logic [4:0] ldiff;
    logic cy;
    logic cy_new;
    logic ac_new;
    logic [7:0] adj;
    a = regs_reg[bal_pkg::BAL_R_A];
    opnd = 8'h00;
    diff = 9'h000;
    ldiff = 5'h00;
    cy = flags_reg[bal_pkg::BAL_F_CY];
    cy_new = cy;
    ac_new = flags_reg[bal_pkg::BAL_F_AC];
    adj = 8'h00;
    alu_res = 8'h00;
    wr_acc = 1'b0;
    wr_dst = 1'b0;
    wr_flags = 1'b0;
    case (op_reg)
      bal_pkg::BAL_OP_SBB_REG, bal_pkg::BAL_OP_SBB_MEM, bal_pkg::BAL_OP_SBB_IMM: begin
        opnd = (op_reg == bal_pkg::BAL_OP_SBB_REG) ? regs_reg[src_reg] :
               (op_reg == bal_pkg::BAL_OP_SBB_MEM) ? mem_byte : imm_reg;
        diff = {1'b0, a} - {1'b0, opnd} - {8'h00, cy};
        ldiff = {1'b0, a[3:0]} - {1'b0, opnd[3:0]} - {4'h0, cy};
        alu_res = diff[7:0];
        cy_new = diff[8];
        ac_new = ~ldiff[4];
        wr_acc = 1'b1;
        wr_flags = 1'b1;
      end
      bal_pkg::BAL_OP_INC_REG, bal_pkg::BAL_OP_INC_MEM: begin
        opnd = (op_reg == bal_pkg::BAL_OP_INC_REG) ? regs_reg[dst_reg] : mem_byte;
        alu_res = opnd + 8'h01;
        ac_new = (opnd[3:0] == 4'hf);
        wr_dst = (op_reg == bal_pkg::BAL_OP_INC_REG);
        wr_flags = 1'b1;
      end
      bal_pkg::BAL_OP_DEC_REG, bal_pkg::BAL_OP_DEC_MEM: begin
        opnd = (op_reg == bal_pkg::BAL_OP_DEC_REG) ? regs_reg[dst_reg] : mem_byte;
        alu_res = opnd - 8'h01;
        ac_new = (opnd[3:0] != 4'h0);
        wr_dst = (op_reg == bal_pkg::BAL_OP_DEC_REG);
        wr_flags = 1'b1;
      end
      bal_pkg::BAL_OP_DEC_ADJ: begin
        adj = a;
        if (a[3:0] > bal_pkg::BAL_BCD_MAX || flags_reg[bal_pkg::BAL_F_AC]) begin
          adj = a + bal_pkg::BAL_ADJ_LOW;
        end
        ac_new = (a[3:0] > bal_pkg::BAL_BCD_MAX);
        cy_new = cy;
        if (adj[7:4] > bal_pkg::BAL_BCD_MAX || cy || (adj < a)) begin
          cy_new = 1'b1;
          adj = adj + bal_pkg::BAL_ADJ_HIGH;
        end
        alu_res = adj;
        wr_acc = 1'b1;
        wr_flags = 1'b1;
      end
      bal_pkg::BAL_OP_AND_REG, bal_pkg::BAL_OP_AND_MEM, bal_pkg::BAL_OP_AND_IMM: begin
        opnd = (op_reg == bal_pkg::BAL_OP_AND_REG) ? regs_reg[src_reg] :
               (op_reg == bal_pkg::BAL_OP_AND_MEM) ? mem_byte : imm_reg;
        alu_res = a & opnd;
        cy_new = 1'b0;
        ac_new = 1'b0;
        wr_acc = 1'b1;
        wr_flags = 1'b1;
      end
      bal_pkg::BAL_OP_XOR_REG, bal_pkg::BAL_OP_XOR_MEM, bal_pkg::BAL_OP_XOR_IMM: begin
        opnd = (op_reg == bal_pkg::BAL_OP_XOR_REG) ? regs_reg[src_reg] :
               (op_reg == bal_pkg::BAL_OP_XOR_MEM) ? mem_byte : imm_reg;
        alu_res = a ^ opnd;
        cy_new = 1'b0;
        ac_new = 1'b0;
        wr_acc = 1'b1;
        wr_flags = 1'b1;
      end
      bal_pkg::BAL_OP_OR_REG: begin
        alu_res = a | regs_reg[src_reg];
        cy_new = 1'b0;
        ac_new = 1'b0;
        wr_acc = 1'b1;
        wr_flags = 1'b1;
      end
      default: begin
        alu_res = 8'h00;
      end
    endcase
    new_flags = flags_reg;
    new_flags[bal_pkg::BAL_F_Z] = z_f;
    new_flags[bal_pkg::BAL_F_S] = s_f;
    new_flags[bal_pkg::BAL_F_P] = p_f;
    new_flags[bal_pkg::BAL_F_AC] = ac_new;
    new_flags[bal_pkg::BAL_F_CY] = cy_new;
  end

  // ------------------------------------------------------------
  // 16-bit pair datapath
  // ------------------------------------------------------------
  always_comb begin
    case (rp_reg)
      bal_pkg::BAL_RP_BC: pair_val = {regs_reg[bal_pkg::BAL_R_B], regs_reg[bal_pkg::BAL_R_C]};
      bal_pkg::BAL_RP_DE: pair_val = {regs_reg[bal_pkg::BAL_R_D], regs_reg[bal_pkg::BAL_R_E]};
      bal_pkg::BAL_RP_HL: pair_val = pointer_pair;
      default: pair_val = sp_reg;
    endcase
    dad_sum = {1'b0, pointer_pair} + {1'b0, pair_val};
    if (op_reg == bal_pkg::BAL_OP_PAIR_INC) begin
      pair_res = pair_val + 16'h0001;
    end else begin
      pair_res = pair_val - 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_reg <= BAL_ST_IDLE;
      op_reg <= bal_pkg::BAL_OP_NONE;
      dst_reg <= 3'h0;
      src_reg <= 3'h0;
      rp_reg <= 2'h0;
      imm_reg <= 8'h00;
      cnt_reg <= 4'h0;
    end else begin
      case (st_reg)
        BAL_ST_IDLE: begin
          if (op_valid) begin
            op_reg <= op_code;
            dst_reg <= destination_field;
            src_reg <= source_field;
            rp_reg <= selected_pair;
            imm_reg <= imm_byte;
            st_reg <= BAL_ST_DONE;
            if (op_code inside {bal_pkg::BAL_OP_SBB_MEM, bal_pkg::BAL_OP_AND_MEM,
                                bal_pkg::BAL_OP_XOR_MEM, bal_pkg::BAL_OP_INC_MEM,
                                bal_pkg::BAL_OP_DEC_MEM}) begin
              st_reg <= BAL_ST_READ;
            end else if (op_code == bal_pkg::BAL_OP_PAIR_ADD) begin
              cnt_reg <= bal_pkg::BAL_CYC_DAD;
              st_reg <= BAL_ST_WAIT;
            end else if (op_code inside {bal_pkg::BAL_OP_PAIR_INC,
                                         bal_pkg::BAL_OP_PAIR_DEC}) begin
              cnt_reg <= bal_pkg::BAL_CYC_PAIR;
              st_reg <= BAL_ST_WAIT;
            end
          end
        end
        BAL_ST_READ: begin
          if (mem_done) begin
            st_reg <= is_rmw_op ? BAL_ST_WRITE : BAL_ST_DONE;
          end
        end
        BAL_ST_WRITE: begin
          if (mem_done) begin
            st_reg <= BAL_ST_DONE;
          end
        end
        BAL_ST_WAIT: begin
          cnt_reg <= cnt_reg - 4'h1;
          if (cnt_reg == 4'h1) begin
            st_reg <= BAL_ST_DONE;
          end
        end
        BAL_ST_DONE: begin
          st_reg <= BAL_ST_IDLE;
        end
        default: begin
          st_reg <= BAL_ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // register file and flags; committed once, in the done state
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 8; i++) begin
        regs_reg[i] <= bal_pkg::BAL_REG_RST;
      end
      sp_reg <= bal_pkg::BAL_SP_RST;
    end else if (st_reg == BAL_ST_DONE) begin
      if (wr_acc) begin
        regs_reg[bal_pkg::BAL_R_A] <= alu_res;
      end
      if (wr_dst) begin
        regs_reg[dst_reg] <= alu_res;
      end
      if (op_reg == bal_pkg::BAL_OP_PAIR_ADD) begin
        {regs_reg[bal_pkg::BAL_R_H], regs_reg[bal_pkg::BAL_R_L]} <= dad_sum[15:0];
      end else if (is_pair_op) begin
        case (rp_reg)
          bal_pkg::BAL_RP_BC: {regs_reg[bal_pkg::BAL_R_B], regs_reg[bal_pkg::BAL_R_C]} <= pair_res;
          bal_pkg::BAL_RP_DE: {regs_reg[bal_pkg::BAL_R_D], regs_reg[bal_pkg::BAL_R_E]} <= pair_res;
          bal_pkg::BAL_RP_HL: {regs_reg[bal_pkg::BAL_R_H], regs_reg[bal_pkg::BAL_R_L]} <= pair_res;
          default: sp_reg <= pair_res;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      flags_reg <= bal_pkg::BAL_FLAGS_RST;
    end else if (st_reg == BAL_ST_DONE) begin
      if (wr_flags) begin
        flags_reg <= new_flags;
      end else if (op_reg == bal_pkg::BAL_OP_PAIR_ADD) begin
        flags_reg[bal_pkg::BAL_F_CY] <= dad_sum[16];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      op_done_reg <= 1'b0;
    end else begin
      op_done_reg <= (st_reg == BAL_ST_DONE) && !is_mem_op ? 1'b1 : (st_reg == BAL_ST_DONE);
    end
  end
endmodule // bal_core

/* core/bal_flag_calc.sv */
`timescale 1ns/1ps
module bal_flag_calc (
  // result in
  input wire logic [7:0] res,
  // flags out
  output logic zero,
  output logic sign,
  output logic parity
);
  assign zero = (res == 8'h00);
  assign sign = res[7];
  assign parity = ~^res;
endmodule // bal_flag_calc

/* core/bal_mem_port.sv */
`timescale 1ns/1ps
module bal_mem_port (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // request from core
  input wire logic start,
  input wire logic wr,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  output logic done,
  output logic [7:0] rdata_reg,
  // memory bus
  output logic mem_rd_reg,
  output logic mem_wr_reg,
  output logic [15:0] mem_addr_reg,
  output logic [7:0] mem_wdata_reg,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ready
);
  // ------------------------------------------------------------
  // one bus cycle; stretched while memory holds ready low
  // ------------------------------------------------------------
  logic busy_reg;
  assign done = busy_reg && mem_ready;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      busy_reg <= 1'b0;
      mem_rd_reg <= 1'b0;
      mem_wr_reg <= 1'b0;
      mem_addr_reg <= 16'h0000;
      mem_wdata_reg <= 8'h00;
    end else if (start && !busy_reg) begin
      busy_reg <= 1'b1;
      mem_rd_reg <= !wr;
      mem_wr_reg <= wr;
      mem_addr_reg <= addr;
      mem_wdata_reg <= wdata;
    end else if (done) begin
      busy_reg <= 1'b0;
      mem_rd_reg <= 1'b0;
      mem_wr_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 8'h00;
    end else if (done && mem_rd_reg) begin
      rdata_reg <= mem_rdata;
    end
  end
endmodule // bal_mem_port

/* inc/bal_pkg.sv */
package bal_pkg;

  // ------------------------------------------------------------
  // operation codes
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    BAL_OP_NONE       = 5'h00,
    BAL_OP_SBB_REG    = 5'h01,
    BAL_OP_SBB_MEM    = 5'h02,
    BAL_OP_SBB_IMM    = 5'h03,
    BAL_OP_INC_REG    = 5'h04,
    BAL_OP_INC_MEM    = 5'h05,
    BAL_OP_DEC_REG    = 5'h06,
    BAL_OP_DEC_MEM    = 5'h07,
    BAL_OP_PAIR_INC   = 5'h08,
    BAL_OP_PAIR_DEC   = 5'h09,
    BAL_OP_PAIR_ADD   = 5'h0a,
    BAL_OP_DEC_ADJ    = 5'h0b,
    BAL_OP_AND_REG    = 5'h0c,
    BAL_OP_AND_MEM    = 5'h0d,
    BAL_OP_AND_IMM    = 5'h0e,
    BAL_OP_XOR_REG    = 5'h0f,
    BAL_OP_XOR_MEM    = 5'h10,
    BAL_OP_XOR_IMM    = 5'h11,
    BAL_OP_OR_REG     = 5'h12
  } bal_op_t;

  // ------------------------------------------------------------
  // register and pair selectors
  // ------------------------------------------------------------
  localparam logic [2:0] BAL_R_B = 3'h0;
  localparam logic [2:0] BAL_R_C = 3'h1;
  localparam logic [2:0] BAL_R_D = 3'h2;
  localparam logic [2:0] BAL_R_E = 3'h3;
  localparam logic [2:0] BAL_R_H = 3'h4;
  localparam logic [2:0] BAL_R_L = 3'h5;
  localparam logic [2:0] BAL_R_A = 3'h7;
  localparam logic [1:0] BAL_RP_BC = 2'h0;
  localparam logic [1:0] BAL_RP_DE = 2'h1;
  localparam logic [1:0] BAL_RP_HL = 2'h2;
  localparam logic [1:0] BAL_RP_SP = 2'h3;

  // ------------------------------------------------------------
  // flag positions, reset values, constants
  // ------------------------------------------------------------
  localparam int BAL_F_CY = 0;
  localparam int BAL_F_P  = 2;
  localparam int BAL_F_AC = 4;
  localparam int BAL_F_Z  = 6;
  localparam int BAL_F_S  = 7;
  localparam logic [7:0] BAL_FLAGS_RST = 8'h02;
  localparam logic [7:0] BAL_REG_RST = 8'h00;
  localparam logic [15:0] BAL_SP_RST = 16'h0000;
  localparam logic [3:0] BAL_BCD_MAX = 4'h9;
  localparam logic [7:0] BAL_ADJ_LOW = 8'h06;
  localparam logic [7:0] BAL_ADJ_HIGH = 8'h60;
  // internal clock counts after memory cycles (base states minus bus states)
  localparam logic [3:0] BAL_CYC_PAIR = 4'h2;
  localparam logic [3:0] BAL_CYC_DAD = 4'h6;

endpackage

/* tb/bal_core_chk.sv */
`timescale 1ns/1ps
module bal_core_chk (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // request side
  input wire logic op_valid,
  input wire bal_pkg::bal_op_t op_code,
  input wire logic [1:0] selected_pair,
  input wire logic op_ready,
  input wire logic op_done_reg,
  // state
  input wire logic [7:0] acc_reg,
  input wire logic [7:0] flags_reg,
  input wire logic [15:0] pointer_pair,
  input wire logic [15:0] bc_out,
  input wire logic [15:0] de_out,
  input wire logic [15:0] sp_out,
  // memory bus
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ready
);
  logic take;
  logic [4:0] oc;
  logic [4:0] lo_reg;
  logic cy_reg;
  logic [7:0] got_reg;
  logic [15:0] sel;
  logic [16:0] dad_sum;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  assign take = op_valid && op_ready;
  assign oc = op_code;
  assign sel = selected_pair == 2'h0 ? bc_out : selected_pair == 2'h1 ? de_out :
    selected_pair == 2'h2 ? pointer_pair : sp_out;
  assign dad_sum = {1'b0, pointer_pair} + {1'b0, sel};
  // op and carry as they stood when the op was taken
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lo_reg <= 5'h00;
      cy_reg <= 1'b0;
    end else if (take) begin
      lo_reg <= oc;
      cy_reg <= flags_reg[0];
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      got_reg <= 8'h00;
    end else if (mem_rd && mem_ready) begin
      got_reg <= mem_rdata;
    end
  end
  sequence s_reg_take;
    take && (oc inside {5'h04, 5'h06, 5'h0c, 5'h0f, 5'h12});
  endsequence
  sequence s_busy_done;
    ##1 !op_ready ##1 op_done_reg;
  endsequence
  a_reg_op_timing: assert property (s_reg_take |-> s_busy_done)
    else $error("register op late");
  a_pair_keep_flags: assert property (take && (oc inside {5'h08, 5'h09}) |->
    ##4 op_done_reg && flags_reg == $past(flags_reg, 4)) else $error("pair op touched flags");
  a_pair_add_sum: assert property (take && oc == 5'h0a |-> ##8 op_done_reg &&
    {flags_reg[0], pointer_pair} == $past(dad_sum, 8) &&
    (flags_reg >> 1) == ($past(flags_reg, 8) >> 1)) else $error("pair add wrong");
  a_logic_clears: assert property (op_done_reg && lo_reg inside {[5'h0c:5'h12]} |->
    !flags_reg[0] && (lo_reg < 5'h0e || !flags_reg[4])) else $error("carry not cleared");
  a_zsp_result: assert property (op_done_reg &&
    lo_reg inside {[5'h01:5'h03], [5'h0b:5'h12]} |-> flags_reg[7] == acc_reg[7] &&
    flags_reg[6] == (acc_reg == 8'h00) && flags_reg[2] == ~^acc_reg) else $error("zsp wrong");
  a_incdec_carry: assert property (op_done_reg && lo_reg inside {[5'h04:5'h07]} |->
    flags_reg[0] == cy_reg) else $error("inc or dec moved carry");
  a_mem_addr_ptr: assert property ((mem_rd || mem_wr) |->
    mem_addr == pointer_pair) else $error("bus address not pointer pair");
  a_rmw_data: assert property (mem_wr |->
    mem_wdata == (lo_reg == 5'h05 ? got_reg + 8'h01 : got_reg - 8'h01)) else $error("bad write");
  a_wait_holds: assert property ((mem_rd || mem_wr) && !mem_ready |=>
    $stable(mem_rd) && $stable(mem_wr) && $stable(mem_addr)) else $error("bus dropped in wait");
endmodule // bal_core_chk
bind bal_core bal_core_chk CHK (.clk_sys, .nrst, .op_valid, .op_code, .selected_pair, .op_ready,
  .op_done_reg, .acc_reg, .flags_reg, .pointer_pair, .bc_out, .de_out, .sp_out, .mem_rd,
  .mem_wr, .mem_addr, .mem_wdata, .mem_rdata, .mem_ready);

/* tb/bal_mem_model.sv */
`timescale 1ns/1ps
module bal_mem_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // bus from the core
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  output logic mem_ready
);
  logic [7:0] mem [0:65535];
  int wait_cycles = 0;
  int rd_cnt = 0;
  int wr_cnt = 0;
  int cnt_reg;
  logic [7:0] junk_reg;
  // ready only after the programmed wait states, bus held meanwhile
  assign mem_ready = (mem_rd || mem_wr) && (cnt_reg == wait_cycles);
  // outside a ready read the data lines carry a changing pattern, never the last byte
  assign mem_rdata = (mem_rd && mem_ready) ? mem[mem_addr] : junk_reg;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 0;
      junk_reg <= 8'h5a;
    end else begin
      junk_reg <= ~junk_reg;
      if (mem_ready) begin
        cnt_reg <= 0;
      end else if (mem_rd || mem_wr) begin
        cnt_reg <= cnt_reg + 1;
      end
    end
  end
  always @(posedge clk_sys) begin
    if (mem_wr && mem_ready) begin
      mem[mem_addr] <= mem_wdata;
      wr_cnt <= wr_cnt + 1;
    end
    if (mem_rd && mem_ready) begin
      rd_cnt <= rd_cnt + 1;
    end
  end
endmodule // bal_mem_model

/* tb/test_byte_alu_arith_logic_ops.sv */
`timescale 1ns/1ps
module test_byte_alu_arith_logic_ops;
  typedef struct packed {
    logic [4:0] op;
    logic [2:0] r;
    logic [7:0] imm;
    logic [7:0] acc;
    logic [7:0] flg;
    logic [7:0] msk;
  } bal_row_t;
  localparam int NROWS = 24;
  localparam int LIMIT = 3000;
  // mask c5 leaves aux carry out where its value is a design choice
  localparam bal_row_t ROWS [NROWS] = '{
    '{5'h11,3'h0,8'h9a,8'h9a,8'h86,8'hd5}, '{5'h03,3'h0,8'h1b,8'h7f,8'h02,8'hc5},
    '{5'h03,3'h0,8'h80,8'hff,8'h87,8'hc5}, '{5'h0e,3'h0,8'h0f,8'h0f,8'h06,8'hd5},
    '{5'h02,3'h0,8'h00,8'hda,8'h83,8'hc5}, '{5'h03,3'h0,8'h5a,8'h7f,8'h02,8'hc5},
    '{5'h03,3'h0,8'h80,8'hff,8'h87,8'hc5}, '{5'h04,3'h7,8'h00,8'h00,8'h57,8'hd5},
    '{5'h06,3'h7,8'h00,8'hff,8'h87,8'hd5}, '{5'h0f,3'h7,8'h00,8'h00,8'h46,8'hd5},
    '{5'h06,3'h0,8'h00,8'h00,8'h86,8'hd5}, '{5'h03,3'h0,8'h01,8'hff,8'h87,8'hc5},
    '{5'h0c,3'h0,8'h00,8'hff,8'h86,8'hc5}, '{5'h11,3'h0,8'hff,8'h00,8'h46,8'hd5},
    '{5'h03,3'h0,8'h01,8'hff,8'h87,8'hc5}, '{5'h12,3'h0,8'h00,8'hff,8'h86,8'hd5},
    '{5'h10,3'h0,8'h00,8'hca,8'h86,8'hd5}, '{5'h0d,3'h0,8'h00,8'h00,8'h46,8'hc5},
    '{5'h11,3'h0,8'h9b,8'h9b,8'h82,8'hd5}, '{5'h0b,3'h0,8'h00,8'h01,8'h13,8'hd5},
    '{5'h0b,3'h0,8'h00,8'h67,8'h03,8'hd4}, '{5'h05,3'h0,8'h00,8'h67,8'h07,8'hd5},
    '{5'h07,3'h0,8'h00,8'h67,8'h17,8'hd5}, '{5'h01,3'h0,8'h00,8'h67,8'h03,8'hc5}};
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic op_valid = 1'b0;
  bal_pkg::bal_op_t op_code = bal_pkg::BAL_OP_NONE;
  logic [2:0] destination_field = 3'h0;
  logic [2:0] source_field = 3'h0;
  logic [1:0] selected_pair = 2'h0;
  logic [7:0] imm_byte = 8'h00;
  logic op_ready, op_done_reg, mem_rd, mem_wr, mem_ready;
  logic [7:0] acc_reg, flags_reg, mem_wdata, mem_rdata;
  logic [15:0] pointer_pair, bc_out, de_out, sp_out, mem_addr;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int c0, c1, wsave;
  logic [7:0] fsave;

  always #25 clk_sys = ~clk_sys;

  bal_core DUT (.clk_sys, .nrst, .op_valid, .op_code, .destination_field, .source_field,
    .selected_pair, .imm_byte, .op_ready, .op_done_reg, .acc_reg, .flags_reg, .pointer_pair,
    .bc_out, .de_out, .sp_out, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata, .mem_ready);
  bal_mem_model u_mem (.clk_sys, .nrst, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata,
    .mem_ready);

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // entered 5 ns after an edge; counts from the taking edge to the edge that samples done
  task automatic run_op(input logic [4:0] op, input logic [2:0] r, input logic [1:0] p,
    input logic [7:0] im, output int n);
    op_code = bal_pkg::bal_op_t'(op);
    destination_field = r;
    source_field = r;
    selected_pair = p;
    imm_byte = im;
    op_valid = 1'b1;
    n = 1;
    // ready is looked at off the edge, where it has settled
    while (op_ready !== 1'b1) begin
      @(posedge clk_sys);
      #5;
    end
    @(posedge clk_sys);
    #5;
    op_valid = 1'b0;
    do begin
      @(posedge clk_sys);
      #5;
      n++;
    end while (op_done_reg !== 1'b1 && n < 300);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_count++;
      $display("ERROR watchdog expected finish seen hang");
      give_verdict();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    u_mem.mem[0] = 8'h35;
    repeat (3) @(posedge clk_sys);
    #5;
    nrst = 1'b1;
    for (int i = 0; i < NROWS; i++) begin
      run_op(ROWS[i].op, ROWS[i].r, 2'h0, ROWS[i].imm, c0);
      check("acc", 16'(acc_reg), 16'(ROWS[i].acc));
      check("flags", 16'(flags_reg & ROWS[i].msk), 16'(ROWS[i].flg & ROWS[i].msk));
    end
    check("mem_byte", 16'(u_mem.mem[0]), 16'h0035);
    check("bc_pair", bc_out, 16'hff00);
    $display("table test done");
    // wait states stretch each bus cycle by exactly their count
    run_op(5'h02, 3'h0, 2'h0, 8'h00, c0);
    u_mem.wait_cycles = 3;
    run_op(5'h02, 3'h0, 2'h0, 8'h00, c1);
    check("sbb_mem_cycles", 16'(c0), 16'h0004);
    check("sbb_wait_stretch", 16'(c1 - c0), 16'h0003);
    u_mem.wait_cycles = 2;
    wsave = u_mem.wr_cnt;
    run_op(5'h05, 3'h0, 2'h0, 8'h00, c1);
    u_mem.wait_cycles = 0;
    run_op(5'h07, 3'h0, 2'h0, 8'h00, c0);
    check("rmw_wait_stretch", 16'(c1 - c0), 16'h0004);
    check("rmw_writes", 16'(u_mem.wr_cnt - wsave), 16'h0002);
    check("rmw_byte", 16'(u_mem.mem[0]), 16'h0035);
    run_op(5'h0c, 3'h0, 2'h0, 8'h00, c0);
    check("reg_op_cycles", 16'(c0), 16'h0002);
    $display("wait test done");
    fsave = flags_reg;
    run_op(5'h09, 3'h0, 2'h0, 8'h00, c0);
    check("bc_dec", bc_out, 16'hfeff);
    check("pair_cycles", 16'(c0), 16'h0004);
    run_op(5'h08, 3'h0, 2'h1, 8'h00, c0);
    check("de_inc", de_out, 16'h0001);
    run_op(5'h09, 3'h0, 2'h3, 8'h00, c0);
    check("sp_dec_wrap", sp_out, 16'hffff);
    run_op(5'h08, 3'h0, 2'h3, 8'h00, c0);
    check("sp_inc_wrap", sp_out, 16'h0000);
    check("pair_flags", 16'(flags_reg), 16'(fsave));
    run_op(5'h0a, 3'h0, 2'h0, 8'h00, c0);
    check("add_no_carry", 16'(flags_reg[0]), 16'h0000);
    check("add_sum", pointer_pair, 16'hfeff);
    check("add_cycles", 16'(c0), 16'h0008);
    run_op(5'h0a, 3'h0, 2'h2, 8'h00, c0);
    check("add_ptr", pointer_pair, 16'hfdfe);
    check("add_flags", 16'(flags_reg), 16'({fsave[7:1], 1'b1}));
    $display("pair test done");
    // reset in the middle of a stalled read
    u_mem.wait_cycles = 3;
    op_code = bal_pkg::BAL_OP_INC_MEM;
    op_valid = 1'b1;
    @(posedge clk_sys);
    #5;
    op_valid = 1'b0;
    repeat (2) @(posedge clk_sys);
    #5;
    nrst = 1'b0;
    #10;
    check("reset_state", {acc_reg, flags_reg}, 16'h0002);
    check("reset_ptr", pointer_pair, 16'h0000);
    check("reset_ctrl", 16'({op_ready, mem_rd, mem_wr, op_done_reg}), 16'h0008);
    @(posedge clk_sys);
    #5;
    nrst = 1'b1;
    run_op(5'h11, 3'h0, 2'h0, 8'h3c, c0);
    check("after_reset", {acc_reg, flags_reg}, 16'h3c06);
    $display("reset test done");
    give_verdict();
  end
endmodule // test_byte_alu_arith_logic_ops
